// ### memmap_pkg.sv
// package of offsets, field positions, reset values and sizes for the banked memory map
package memmap_pkg;
   // program memory geometry
   localparam int unsigned PC_W          = 13;            // full program counter width
   localparam int unsigned PROG_AW       = 10;            // fitted words address width (1K)
   localparam logic [12:0] RESET_VECTOR  = 13'h0000;      // fetch start after reset
   localparam logic [12:0] IRQ_VECTOR    = 13'h0004;      // fetch start on interrupt
   localparam int unsigned STACK_DEPTH   = 8;             // return stack entries
   localparam int unsigned STACK_PW      = 3;             // stack pointer width
   // data memory geometry
   localparam int unsigned GPR_DEPTH     = 64;            // general purpose bytes
   localparam int unsigned GPR_AW        = 6;             // general purpose index width
   localparam logic [6:0]  GPR_LO        = 7'h20;         // first shared location
   localparam logic [6:0]  GPR_HI        = 7'h5F;         // last shared location
   localparam logic [6:0]  SFR_LIMIT     = 7'h20;         // locations below are special registers
   // register offsets; core ones same in both banks, port ones banked
   localparam logic [6:0]  OFS_INDIRECT  = 7'h00;         // indirect data port
   localparam logic [6:0]  OFS_PCL       = 7'h02;         // program counter low
   localparam logic [6:0]  OFS_STATUS    = 7'h03;         // core status
   localparam logic [6:0]  OFS_POINTER   = 7'h04;         // indirect pointer
   localparam logic [6:0]  OFS_PROGRAM_COUNTER_UPPER_LATCH    = 7'h0A;         // program counter upper latch
   localparam logic [6:0]  OFS_INTCTL    = 7'h0B;         // interrupt control
   localparam logic [6:0]  OFS_PORT      = 7'h05;         // port data (bank 0)
   localparam logic [6:0]  OFS_DIR       = 7'h05;         // port direction (bank 1)
   localparam logic [6:0]  OFS_PULLUP    = 7'h15;         // pull-up enables (bank 1)
   localparam logic [6:0]  OFS_IOC       = 7'h16;         // change interrupt enables (bank 1)
   // status fields
   localparam int unsigned ST_BANK_BIT   = 5;             // bank select bit position
   localparam int unsigned ST_TO_BIT     = 4;             // time-out flag position
   localparam int unsigned ST_PD_BIT     = 3;             // power-down flag position
   localparam logic [7:0]  ST_WR_MASK    = 8'hE7;         // bits software may write
   localparam logic [7:0]  STATUS_RST    = 8'h18;         // status after reset
   localparam logic [7:0]  INTCTL_RST    = 8'h00;         // interrupt control after reset
   localparam int unsigned INT_GPIF_BIT  = 0;             // port change flag position
   localparam int unsigned INT_GPIE_BIT  = 3;             // port change enable position
   // port fields
   localparam int unsigned PORT_W        = 6;             // port pin count
   localparam int unsigned IN_ONLY_PIN   = 3;             // pin shared with master clear
   localparam logic [5:0]  DIR_RST       = 6'h3F;         // all pins inputs after reset
   localparam logic [5:0]  PULLUP_RST    = 6'h37;         // pull-ups after reset
   localparam logic [5:0]  IOC_RST       = 6'h00;         // change enables after reset
   // timing
   localparam real         CLK_MHZ       = 250.0;         // system clock rate
   localparam real         INSTR_NS      = 200.0;         // instruction cycle at 20 MHz
   localparam int unsigned INSTR_CYC     = int'(INSTR_NS * CLK_MHZ / 1000.0); // clocks per cycle
endpackage

// ### return_stack.sv
// eight-entry circular return-address stack
`timescale 1ns/1ps
module return_stack
(
   input  wire logic        clk_sys,   // system clock
   input  wire logic        arst_n,    // async reset, active low
   input  wire logic        clk_en,    // freezes state while low
   input  wire logic        push,      // store a return address
   input  wire logic        pop,       // take the top address
   input  wire logic [12:0] push_addr, // address to store
   output logic      [12:0] top_addr   // address at the top
);
   logic [12:0] entry_q [memmap_pkg::STACK_DEPTH]; // stack storage
   logic [2:0]  ptr_q;                             // next free slot
   logic [2:0]  top_idx;                           // slot of the top entry

   // overflow silently wraps and overwrites the oldest entry, as on the real core
   assign top_idx  = ptr_q - 3'h1;
   assign top_addr = entry_q[top_idx];

   // pointer moves; push wins if both asked in one cycle
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ptr_q <= 3'h0;
      else if (clk_en && push)
         ptr_q <= ptr_q + 3'h1;
      else if (clk_en && pop)
         ptr_q <= top_idx;
   end

   // entry storage, one flop group per slot
   genvar gi;
   generate
      for (gi = 0; gi < memmap_pkg::STACK_DEPTH; gi++)
      begin : g_slot
         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
               entry_q[gi] <= 13'h0000;
            else if (clk_en && push && ptr_q == 3'(gi))
               entry_q[gi] <= push_addr;
         end
      end
   endgenerate
endmodule

// ### banked_memory_map.sv
// banked data memory map, program address generation and port pins
`timescale 1ns/1ps
module banked_memory_map
(
   input  wire logic        clk_sys,      // system clock
   input  wire logic        arst_n,       // async reset, active low
   input  wire logic        clk_en,       // freezes state while low
   // fetch side
   input  wire logic        pc_step,      // advance to next instruction
   input  wire logic        pc_jump,      // load jump target
   input  wire logic [10:0] jump_target,  // low 11 bits of jump target
   input  wire logic        call_req,     // jump and push return address
   input  wire logic        return_req,   // pop return address
   input  wire logic        irq_take,     // interrupt taken, vector and push
   output logic      [12:0] prog_addr,    // full program counter
   output logic      [9:0]  prog_word,    // fitted word address
   output logic             instr_tick,   // one pulse per instruction cycle
   // data side
   input  wire logic [6:0]  file_addr,    // direct address from instruction
   input  wire logic        file_rd,      // read strobe
   input  wire logic        file_wr,      // write strobe
   input  wire logic [7:0]  file_wdata,   // write data
   output logic      [7:0]  file_rdata,   // read data, one cycle after strobe
   output logic             bank_sel,     // current direct bank
   output logic             change_irq,   // port change interrupt request
   // port pins
   input  wire logic [5:0]  pin_in,       // pin levels from pads
   output logic      [5:0]  pin_out,      // pin drive values
   output logic      [5:0]  pin_oe,       // high while pin driven
   output logic      [5:0]  pullup_en     // weak pull-up enables
);
   // ---------------- program counter ----------------
   logic [12:0] pc_q;        // program counter
   logic [12:0] pc_d;        // next counter value
   logic [7:0]  program_counter_upper_latch_q;    // upper latch, low 5 bits used
   logic [12:0] stack_top;   // top of return stack
   logic [12:0] pc_inc;      // counter plus one
   logic [12:0] pc_goto;     // jump target merged with latch
   logic [12:0] pc_write;    // counter after software writes low byte
   logic        wr_pcl;      // software write to counter low

   // full 13-bit counter kept even though only 1K is fitted
   assign pc_inc   = pc_q + 13'h0001;
   assign pc_goto  = {program_counter_upper_latch_q[4:3], jump_target};
   assign pc_write = {program_counter_upper_latch_q[4:0], file_wdata};

   // fetch priority: interrupt, return, jump or call, register write, step
   always_comb
   begin
      pc_d = pc_q;
      if (irq_take)
         pc_d = memmap_pkg::IRQ_VECTOR;
      else if (return_req)
         pc_d = stack_top;
      else if (pc_jump || call_req)
         pc_d = pc_goto;
      else if (wr_pcl)
         pc_d = pc_write;
      else if (pc_step)
         pc_d = pc_inc;
   end

   // counter register
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         pc_q <= memmap_pkg::RESET_VECTOR;
      else if (clk_en)
         pc_q <= pc_d;
   end

   assign prog_addr = pc_q;
   // only low bits select a word, so high addresses wrap into 1K
   assign prog_word = pc_q[memmap_pkg::PROG_AW-1:0];

   // return stack; a call pushes the address after the current word, an interrupt pushes the current word
   return_stack u_stack
   (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .push      (call_req || irq_take),
      .pop       (return_req && !irq_take),
      .push_addr (irq_take ? pc_q : pc_inc),
      .top_addr  (stack_top)
   );

   // ---------------- instruction cycle timer ----------------
   localparam int unsigned TW = $clog2(memmap_pkg::INSTR_CYC);
   logic [TW-1:0] tick_cnt_q;   // clocks within an instruction cycle
   logic          tick_q;       // cycle boundary pulse
   logic          tick_wrap;    // last clock of the cycle

   assign tick_wrap = (tick_cnt_q == TW'(memmap_pkg::INSTR_CYC - 1));

   // free-running divider giving one pulse per 200 ns
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1);
         tick_q     <= tick_wrap;
      end
   end
   assign instr_tick = tick_q;

   // ---------------- data address decode ----------------
   logic [7:0] status_q;     // core status
   logic [7:0] pointer_q;    // indirect pointer
   logic [7:0] intctl_q;     // interrupt control
   logic [7:0] eff_addr;     // full 8-bit data address
   logic [6:0] ofs;          // offset within bank
   logic       bank;         // bank of the access
   logic       is_indirect;  // direct address names the indirect port
   logic       is_sfr;       // special register region
   logic       is_gpr;       // shared storage region
   logic       wr_en;        // qualified write

   assign is_indirect = (file_addr == memmap_pkg::OFS_INDIRECT);
   // indirect access takes all eight pointer bits; direct uses the bank bit
   assign eff_addr = is_indirect ? pointer_q
                                 : {status_q[memmap_pkg::ST_BANK_BIT], file_addr};
   assign bank     = eff_addr[7];
   assign ofs      = eff_addr[6:0];
   assign is_sfr   = (ofs < memmap_pkg::SFR_LIMIT);
   // bank bit ignored here so both banks reach the same bytes
   assign is_gpr   = (ofs >= memmap_pkg::GPR_LO) && (ofs <= memmap_pkg::GPR_HI);
   assign wr_en    = clk_en && file_wr;
   assign bank_sel = status_q[memmap_pkg::ST_BANK_BIT];

   // register selects; core registers ignore the bank
   logic sel_pcl, sel_status, sel_pointer, sel_program_counter_upper_latch, sel_intctl;
   logic sel_port, sel_dir, sel_pullup, sel_ioc;
   assign sel_pcl     = (ofs == memmap_pkg::OFS_PCL);
   assign sel_status  = (ofs == memmap_pkg::OFS_STATUS);
   assign sel_pointer = (ofs == memmap_pkg::OFS_POINTER);
   assign sel_program_counter_upper_latch  = (ofs == memmap_pkg::OFS_PROGRAM_COUNTER_UPPER_LATCH);
   assign sel_intctl  = (ofs == memmap_pkg::OFS_INTCTL);
   assign sel_port    = !bank && (ofs == memmap_pkg::OFS_PORT);
   assign sel_dir     =  bank && (ofs == memmap_pkg::OFS_DIR);
   assign sel_pullup  =  bank && (ofs == memmap_pkg::OFS_PULLUP);
   assign sel_ioc     =  bank && (ofs == memmap_pkg::OFS_IOC);
   // the indirect port through itself is a null access
   assign wr_pcl      = wr_en && sel_pcl && !(is_indirect && pointer_q[6:0] == memmap_pkg::OFS_INDIRECT);

   // ---------------- general purpose storage ----------------
   logic [7:0] gpr_q [memmap_pkg::GPR_DEPTH];  // shared bytes
   logic [5:0] gpr_idx;                        // storage index
   assign gpr_idx = 6'(ofs - memmap_pkg::GPR_LO);

   // one flop byte per location; no reset, contents unknown at power-up as in RAM
   genvar gi;
   generate
      for (gi = 0; gi < memmap_pkg::GPR_DEPTH; gi++)
      begin : g_gpr
         always_ff @(posedge clk_sys)
         begin
            if (wr_en && is_gpr && gpr_idx == 6'(gi))
               gpr_q[gi] <= file_wdata;
         end
      end
   endgenerate

   // ---------------- core registers ----------------
   // status: reserved bits are stored as written, software keeps them clear
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         status_q <= memmap_pkg::STATUS_RST;
      else if (wr_en && sel_status)
         status_q <= (file_wdata & memmap_pkg::ST_WR_MASK)
                   | (status_q & ~memmap_pkg::ST_WR_MASK);
   end

   // pointer and upper latch
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pointer_q <= 8'h00;
         program_counter_upper_latch_q  <= 8'h00;
      end
      else if (wr_en)
      begin
         if (sel_pointer)
            pointer_q <= file_wdata;
         if (sel_program_counter_upper_latch)
            program_counter_upper_latch_q <= {3'h0, file_wdata[4:0]};
      end
   end

   // ---------------- port pins ----------------
   logic [5:0] pin_s1_q, pin_s2_q;  // input synchroniser stages
   logic [5:0] pin_last_q;          // levels at last port read or write
   logic [5:0] latch_q;             // output latch
   logic [5:0] dir_q;               // 1 = input
   logic [5:0] pullup_q;            // pull-up enables
   logic [5:0] ioc_q;               // change enables
   logic [5:0] changed;             // enabled pins that moved
   logic       rd_port;             // software reads port

   // two-flop synchroniser on the pad levels
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end
      else if (clk_en)
      begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   assign rd_port = clk_en && file_rd && sel_port;
   assign changed = (pin_s2_q ^ pin_last_q) & ioc_q;

   // port configuration registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         latch_q  <= 6'h00;
         dir_q    <= memmap_pkg::DIR_RST;
         pullup_q <= memmap_pkg::PULLUP_RST;
         ioc_q    <= memmap_pkg::IOC_RST;
      end
      else if (wr_en)
      begin
         if (sel_port)
            latch_q <= file_wdata[5:0];
         if (sel_dir)
            dir_q <= file_wdata[5:0];
         if (sel_pullup)
            pullup_q <= file_wdata[5:0];
         if (sel_ioc)
            ioc_q <= file_wdata[5:0];
      end
   end

   // mismatch reference is refreshed by a port read or a port write
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         pin_last_q <= 6'h00;
      else if (rd_port || (wr_en && sel_port))
         pin_last_q <= pin_s2_q;
   end

   // interrupt control; a new change beats a software clear of the flag
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         intctl_q <= memmap_pkg::INTCTL_RST;
      else if (clk_en)
      begin
         if (wr_en && sel_intctl)
            intctl_q <= file_wdata;
         if (|changed)
            intctl_q[memmap_pkg::INT_GPIF_BIT] <= 1'b1;
      end
   end

   // pad drive; the master clear pin never drives and has no pull-up
   logic [5:0] oe_d, pu_d;
   assign oe_d = ~dir_q & ~(6'h01 << memmap_pkg::IN_ONLY_PIN);
   assign pu_d = pullup_q & ~(6'h01 << memmap_pkg::IN_ONLY_PIN);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_out    <= 6'h00;
         pin_oe     <= 6'h00;
         pullup_en  <= 6'h00;
         change_irq <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_out    <= latch_q;
         pin_oe     <= oe_d;
         pullup_en  <= pu_d;
         change_irq <= intctl_q[memmap_pkg::INT_GPIF_BIT] & intctl_q[memmap_pkg::INT_GPIE_BIT];
      end
   end

   // ---------------- read mux ----------------
   logic [7:0] rd_mux;  // selected read value
   always_comb
   begin
      rd_mux = 8'h00;
      if (is_indirect && pointer_q[6:0] == memmap_pkg::OFS_INDIRECT)
         rd_mux = 8'h00;
      else if (is_gpr)
         rd_mux = gpr_q[gpr_idx];
      else if (sel_pcl)
         rd_mux = pc_q[7:0];
      else if (sel_status)
         rd_mux = status_q;
      else if (sel_pointer)
         rd_mux = pointer_q;
      else if (sel_program_counter_upper_latch)
         rd_mux = program_counter_upper_latch_q;
      else if (sel_intctl)
         rd_mux = intctl_q;
      else if (sel_port)
         rd_mux = {2'h0, pin_s2_q};
      else if (sel_dir)
         rd_mux = {2'h0, dir_q};
      else if (sel_pullup)
         rd_mux = {2'h0, pullup_q};
      else if (sel_ioc)
         rd_mux = {2'h0, ioc_q};
   end

   // registered read data
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         file_rdata <= 8'h00;
      else if (clk_en && file_rd)
         file_rdata <= rd_mux;
   end
endmodule

// ### banked_memory_map_props.sv
// concurrent checks on the banked memory map ports
`timescale 1ns/1ps
module banked_memory_map_props
(
   input wire logic        clk_sys,     // system clock
   input wire logic        arst_n,      // async reset, active low
   input wire logic        clk_en,      // run enable
   input wire logic        pc_step,     // step request
   input wire logic        pc_jump,     // jump request
   input wire logic [10:0] jump_target, // jump target
   input wire logic        call_req,    // call request
   input wire logic        return_req,  // return request
   input wire logic        irq_take,    // interrupt taken
   input wire logic [12:0] prog_addr,   // program counter
   input wire logic [9:0]  prog_word,   // fitted word address
   input wire logic        instr_tick,  // instruction cycle pulse
   input wire logic [6:0]  file_addr,   // direct offset
   input wire logic        file_rd,     // read strobe
   input wire logic        file_wr,     // write strobe
   input wire logic [7:0]  file_wdata,  // write data
   input wire logic [7:0]  file_rdata,  // read data
   input wire logic        bank_sel,    // direct bank
   input wire logic [5:0]  pin_oe,      // pin drive enables
   input wire logic [5:0]  pullup_en    // pull-up enables
);
   logic [5:0] gap_q;  // clocks since the last tick
   logic       seen_q; // first tick has no reference, so skip it
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // gap counter, so fifty-clock spacing is exact
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gap_q  <= 6'h00;
         seen_q <= 1'b0;
      end
      else
      begin
         gap_q  <= instr_tick ? 6'h00 : gap_q + 6'h01;
         seen_q <= seen_q | instr_tick;
      end
   end
   a_reset_fetch: assert property ($rose(arst_n) |-> prog_addr == 13'h0000)
      else $error("fetch did not start at zero");
   a_irq_vector: assert property (clk_en && irq_take |=> prog_addr == 13'h0004)
      else $error("interrupt did not vector");
   a_word_fold: assert property (prog_word == prog_addr[9:0])
      else $error("word address not folded");
   a_pin_input: assert property (!pin_oe[3] && !pullup_en[3])
      else $error("input only pin driven or pulled");
   a_tick_spacing: assert property (instr_tick && seen_q |-> gap_q == 6'h31)
      else $error("instruction cycle not fifty clocks");
   a_bank_follow: assert property (clk_en && file_wr && file_addr == 7'h03 |=> bank_sel == $past(file_wdata[5]))
      else $error("bank select not taken from status");
   a_jump_load: assert property (clk_en && pc_jump && !irq_take && !return_req
      |=> prog_addr[10:0] == $past(jump_target))
      else $error("jump target not loaded");
   a_step_inc: assert property (clk_en && pc_step && !pc_jump && !call_req && !return_req && !irq_take
      && !file_wr |=> prog_addr == $past(prog_addr) + 13'h0001)
      else $error("step did not advance counter");
   a_unimpl_zero: assert property (clk_en && file_rd && (file_addr inside {[7'h06:7'h09], [7'h60:7'h7F]})
      |=> file_rdata == 8'h00)
      else $error("unbacked location read nonzero");
   a_rdata_hold: assert property (!file_rd |=> $stable(file_rdata))
      else $error("read data moved without a read");
   // main scenarios reached
   cover property (clk_en && irq_take);
   cover property (clk_en && return_req);
   cover property (file_rd && bank_sel && file_addr == 7'h20);
endmodule
bind banked_memory_map banked_memory_map_props u_props
(
   .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .pc_step(pc_step), .pc_jump(pc_jump),
   .jump_target(jump_target), .call_req(call_req), .return_req(return_req), .irq_take(irq_take),
   .prog_addr(prog_addr), .prog_word(prog_word), .instr_tick(instr_tick), .file_addr(file_addr),
   .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata),
   .bank_sel(bank_sel), .pin_oe(pin_oe), .pullup_en(pullup_en)
);

// ### core_port_model.sv
// model of the processor core's fetch and data access
`timescale 1ns/1ps
module core_port_model
(
   input  wire logic        clk_sys,     // system clock
   input  wire logic [7:0]  file_rdata,  // read data
   output logic             pc_step,     // step request
   output logic             pc_jump,     // jump request
   output logic      [10:0] jump_target, // jump target
   output logic             call_req,    // call request
   output logic             return_req,  // return request
   output logic             irq_take,    // interrupt taken
   output logic      [6:0]  file_addr,   // direct offset
   output logic             file_rd,     // read strobe
   output logic             file_wr,     // write strobe
   output logic      [7:0]  file_wdata   // write data
);
   // all strobes idle from time zero
   initial
   begin
      {pc_step, pc_jump, call_req, return_req, irq_take, file_rd, file_wr} = 7'h00;
      jump_target = 11'h000;
      file_addr   = 7'h00;
      file_wdata  = 8'h00;
   end
   // write: hold to the taking edge, then scramble bus
   task automatic fwr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      file_addr  <= a;
      file_wdata <= d;
      file_wr    <= 1'b1;
      @(posedge clk_sys);
      file_wr    <= 1'b0;
      file_addr  <= ~a;
      file_wdata <= ~d;
   endtask
   // read: data sampled mid-cycle after taking edge
   task automatic frd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      file_addr <= a;
      file_rd   <= 1'b1;
      @(posedge clk_sys);
      file_rd   <= 1'b0;
      file_addr <= ~a;
      @(negedge clk_sys);
      d = file_rdata;
   endtask
   // bank change keeps reserved status bits clear
   task automatic bank(input logic b);
      fwr(7'h03, {2'b00, b, 5'h00});
   endtask
   // fetch kinds: 0 step, 1 jump, 2 call, 3 return, 4 interrupt
   task automatic fetch(input logic [2:0] k, input logic [10:0] t);
      @(posedge clk_sys);
      jump_target <= t;
      pc_step     <= (k == 3'd0);
      pc_jump     <= (k == 3'd1);
      call_req    <= (k == 3'd2);
      return_req  <= (k == 3'd3);
      irq_take    <= (k == 3'd4);
      @(posedge clk_sys);
      {pc_step, pc_jump, call_req, return_req, irq_take} <= 5'h00;
      @(negedge clk_sys);
   endtask
endmodule

// ### test_banked_memory_map.sv
// self-checking bench for the banked memory map
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module test_banked_memory_map;
   logic        clk_sys, arst_n, clk_en;                       // clock, reset, enable
   logic        pc_step, pc_jump, call_req, return_req, irq_take; // fetch requests
   logic [10:0] jump_target;                                   // jump target
   logic [12:0] prog_addr;                                     // program counter
   logic [9:0]  prog_word;                                     // fitted word
   logic        instr_tick, bank_sel, file_rd, file_wr, change_irq; // misc strobes
   logic [6:0]  file_addr;                                     // direct offset
   logic [7:0]  file_wdata, file_rdata, rd;                    // data bytes
   logic [5:0]  pin_in, pin_out, pin_oe, pullup_en;            // pins
   int          fail_count, comparisons, n;                    // counters
   logic [6:0] n_list [4] = '{7'h06, 7'h07, 7'h60, 7'h7F}; // unbacked offsets
   banked_memory_map dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .pc_step(pc_step),
      .pc_jump(pc_jump), .jump_target(jump_target), .call_req(call_req), .return_req(return_req),
      .irq_take(irq_take), .prog_addr(prog_addr), .prog_word(prog_word), .instr_tick(instr_tick),
      .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
      .file_rdata(file_rdata), .bank_sel(bank_sel), .change_irq(change_irq), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));
   core_port_model core (.clk_sys(clk_sys), .file_rdata(file_rdata), .pc_step(pc_step),
      .pc_jump(pc_jump), .jump_target(jump_target), .call_req(call_req), .return_req(return_req),
      .irq_take(irq_take), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
      .file_wdata(file_wdata));
   // 250 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // verdict and end of run
   task automatic summarize;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // tests need under 2500 clocks; allow four times
   initial
   begin
      #40000;
      fail_count++;
      $display("[ERR] watchdog expected end seen hang");
      summarize();
   end
   initial
   begin
      {arst_n, clk_en, pin_in, fail_count, comparisons} = {1'b0, 1'b1, 6'h00, 64'h0};
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("reset pc", 13'h0000, prog_addr)
      `CHK("reset pullups", 6'h37, pullup_en)
      core.frd(7'h03, rd);
      `CHK("reset status", 8'h18, rd)
      $display("test reset done");
      // shared bytes, banks and core registers
      core.fwr(7'h20, 8'h55);
      core.bank(1'b1);
      @(negedge clk_sys);
      `CHK("bank", 1'b1, bank_sel)
      core.frd(7'h20, rd);
      `CHK("shared byte", 8'h55, rd)
      core.fwr(7'h5F, 8'hAA);
      core.fwr(7'h04, 8'hE0);
      core.bank(1'b0);
      core.frd(7'h04, rd);
      `CHK("pointer both banks", 8'hE0, rd)
      core.frd(7'h5F, rd);
      `CHK("top shared byte", 8'hAA, rd)
      core.frd(7'h00, rd);
      `CHK("indirect unbacked", 8'h00, rd)
      foreach (n_list[i])
      begin
         core.frd(n_list[i], rd);
         `CHK("unbacked", 8'h00, rd)
      end
      for (int i = 0; i < 64; i++) core.fwr(7'(7'h20 + i), 8'(8'hA5 ^ i));
      for (int i = 0; i < 64; i++)
      begin
         core.fwr(7'h04, 8'(8'hA0 + i));
         core.frd(7'h00, rd);
         `CHK("indirect byte", 8'(8'hA5 ^ i), rd)
      end
      $display("test data map done");
      // fetch: steps, calls, interrupt, latch and wrap
      repeat (3) core.fetch(3'd0, 11'h000);
      `CHK("steps", 13'h0003, prog_addr)
      for (int i = 0; i < 8; i++) core.fetch(3'd2, 11'(11'h100 + i));
      for (int j = 0; j < 8; j++)
      begin
         core.fetch(3'd3, 11'h000);
         `CHK("pop", (j < 7) ? 13'(13'h0107 - j) : 13'h0004, prog_addr)
      end
      core.fetch(3'd0, 11'h000);
      core.fetch(3'd4, 11'h000);
      `CHK("irq vector", 13'h0004, prog_addr)
      core.fetch(3'd3, 11'h000);
      `CHK("irq return", 13'h0005, prog_addr)
      core.fwr(7'h0A, 8'h18);
      core.fetch(3'd1, 11'h7FF);
      `CHK("top address", 13'h1FFF, prog_addr)
      `CHK("folded word", 10'h3FF, prog_word)
      core.fetch(3'd0, 11'h000);
      `CHK("counter wrap", 13'h0000, prog_addr)
      n = 0;
      repeat (500)
      begin
         @(negedge clk_sys);
         n += int'(instr_tick);
      end
      `CHK("ticks", 10, n)
      $display("test fetch done");
      // pins: drive, pull-ups off, change flag
      pin_in <= 6'h2A;
      core.bank(1'b1);
      core.fwr(7'h05, 8'h00);
      core.fwr(7'h15, 8'h00);
      core.fwr(7'h16, 8'h01);
      core.bank(1'b0);
      core.fwr(7'h05, 8'h3F);
      core.fwr(7'h0B, 8'h08);
      pin_in <= 6'h2B;
      repeat (6) @(negedge clk_sys);
      `CHK("drive enables", 6'h37, pin_oe)
      `CHK("pullups off", 6'h00, pullup_en)
      `CHK("drive values", 6'h37, pin_out & 6'h37)
      `CHK("change irq", 1'b1, change_irq)
      $display("test pins done");
      summarize();
   end
endmodule
